// ===== sep_consts.svh
// Constants of the serial EEPROM command and protection block
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

// ****************************************
// Command opcodes
// ****************************************
`define SEP_OP_SET_WEL 8'h06
`define SEP_OP_CLR_WEL 8'h04
`define SEP_OP_SET_FLAG 8'h00
`define SEP_OP_RD_SR 8'h05
`define SEP_OP_WR_SR 8'h01
`define SEP_OP_READ 8'h03
`define SEP_OP_WRITE 8'h02

// ****************************************
// Status register layout
// ****************************************
`define SEP_SR_PROTECT_ENABLE_BIT 7
`define SEP_SR_FLAG 6
`define SEP_SR_WEL 1
`define SEP_SR_BUSY 0
`define SEP_SR_NV_MASK 8'hbc
`define SEP_SR_NV_RESET 8'h00

// ****************************************
// Array geometry and sizes
// ****************************************
`define SEP_ARR_AW 11
`define SEP_ARR_WORDS 2048
`define SEP_PAGE_AW 5
`define SEP_PAGE_BYTES 32
`define SEP_FIFO_W 13
`define SEP_FIFO_DEPTH 32
`define SEP_CNT_W 26
`define SEP_BIT_LAST 3'h7

// ****************************************
// Timing
// ****************************************
`define SEP_CLK_PERIOD_NS 4
`define SEP_NV_WRITE_TIME_NS 5000000
`define SEP_POWER_UP_RESET_TIME_NS 100000000

`endif

// ===== sep_pkg.sv
// Types of the serial EEPROM command and protection block
package sep_pkg;
`include "sep_consts.svh"

    typedef enum logic [3:0] {
        sep_idle, sep_opc, sep_addr, sep_rdata, sep_wdata,
        sep_srrd, sep_srwr, sep_tail, sep_ignore
    } sep_phase_t;

    typedef struct packed {
        sep_phase_t phase;
        logic [2:0] bitcnt;
        logic got_byte;
        logic nbyte;
        logic [7:0] shin;
        logic [7:0] opcode;
        logic [7:0] shout;
        logic [7:0] addr_hi;
        logic [`SEP_ARR_AW-1:0] addr;
        logic write_enable_latch;
        logic flag;
        logic [7:0] nv;
        logic [7:0] pend;
        logic busy;
        logic busy_sr;
        logic [`SEP_CNT_W-1:0] wcnt;
        logic [`SEP_PAGE_AW:0] cidx;
        logic [`SEP_PAGE_BYTES-1:0] pvalid;
        logic sck_q;
        logic cs_q;
        logic [`SEP_CNT_W-1:0] por_cnt;
        logic por_done;
        logic so;
        logic so_oe_n;
        logic reset_out;
    } sep_state_t;

    typedef struct packed {
        logic [$clog2(`SEP_FIFO_DEPTH):0] wptr;
        logic [$clog2(`SEP_FIFO_DEPTH):0] rptr;
    } sep_fifo_state_t;
endpackage

// ===== sep_sync.sv
// Two-flop synchronisers for the pins
`timescale 1ns/1ps
module sep_sync import sep_pkg::*; #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= din[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign dout = sync_r;
endmodule

// ===== sep_fifo.sv
// Write data FIFO between the serial shifter and the page buffer
`timescale 1ns/1ps
module sep_fifo import sep_pkg::*; #(
    parameter int W = `SEP_FIFO_W,
    parameter int DEPTH = `SEP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    sep_fifo_state_t r;
    sep_fifo_state_t s;
    logic [W-1:0] mem [DEPTH];
    logic full;
    logic empty;

    assign full = (r.wptr[AW] != r.rptr[AW]) && (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
    assign empty = (r.wptr == r.rptr);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[r.rptr[AW-1:0]];

    always_comb begin
        s = r;
        if (in_valid && !full) begin
            s.wptr = r.wptr + 1'b1;
        end
        if (out_ready && !empty) begin
            s.rptr = r.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[r.wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end
endmodule

// ===== sep_eeprom.sv
// Serial EEPROM command interface with status-register write protection
//
// Summary of operation
// RULE1 - Pin low with protect bit set refuses status-register nonvolatile writes.
// RULE2 - A status write already running finishes even if the pin falls.
// RULE3 - Pin high lets status writes and everything else work normally.
// RULE4 - Protect bit clear makes the pin irrelevant to status writes.
// RULE5 - Setting protect bit with pin low locks status until pin changes.
// RULE6 - Read: select, read opcode, 16-bit address, then bytes come out.
// RULE7 - Each read byte advances the address so reading continues with clocks.
// RULE8 - Reading past the top address wraps the counter to zero.
// RULE9 - Raising select ends a read at once.
// RULE10 - Status read: select, opcode, then status bits come out.
// RULE11 - Write latch is set only if select rises right after its opcode.
// RULE12 - Array write is opcode, 16-bit address, data; unused address bits zero.
// RULE13 - Master keeps select low for the whole write, at least 32 clocks.
// RULE14 - Data beyond a page end wraps to the page start and overwrites.
// RULE15 - Write starts only if select rises right after a byte's last bit.
// RULE16 - Status write is opcode plus one byte; low two data bits zero.
// RULE17 - During a nonvolatile write, status reads work and show busy high.
// RULE18 - After power-up the part idles until select falls.
// RULE19 - Power-up leaves output released and clears latch and cause flag.
// RULE20 - Power-up holds the reset output for the power-up interval.
// RULE21 - Opcodes: 06 set latch, 04 clear, 00 flag, 05, 01, 03, 02.
// RULE22 - Status bits: protect, flag, four nonvolatile bits, latch, busy.
// RULE23 - Input sampled on rising clock, output on falling, MSB first.
// RULE24 - Write latch clears when a valid nonvolatile write completes.
// RULE25 - Page is 32 bytes; low five address bits are the page offset.
`timescale 1ns/1ps
`include "sep_consts.svh"
module sep_eeprom import sep_pkg::*; #(
    parameter int WRITE_CYCLES = `SEP_NV_WRITE_TIME_NS / `SEP_CLK_PERIOD_NS,
    parameter int POR_CYCLES = `SEP_POWER_UP_RESET_TIME_NS / `SEP_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // Protection pin
    input wire logic wp_n,
    // Power-up reset output
    output logic reset_out
);
    localparam logic [`SEP_CNT_W-1:0] WR_LAST = `SEP_CNT_W'(WRITE_CYCLES - 1);
    localparam logic [`SEP_CNT_W-1:0] POR_LAST = `SEP_CNT_W'(POR_CYCLES - 1);

    sep_state_t r;
    sep_state_t s;
    logic [7:0] mem [`SEP_ARR_WORDS];
    logic [7:0] pbuf [`SEP_PAGE_BYTES];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic wp_s;

    sep_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({cs_n, sck, si, wp_n}),
        .dout(pins_s)
    );
    assign cs_s = pins_s[3];
    assign sck_s = pins_s[2];
    assign si_s = pins_s[1];
    assign wp_s = pins_s[0];

    // ****************************************
    // Write data FIFO
    // ****************************************
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [`SEP_FIFO_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`SEP_FIFO_W-1:0] fifo_out_data;

    sep_fifo #(.W(`SEP_FIFO_W), .DEPTH(`SEP_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    // Buffer stalls while a page is being committed
    assign fifo_out_ready = !r.busy;

    // ****************************************
    // Next state
    // ****************************************
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic locked;
    logic last;
    logic [7:0] nb;
    logic [7:0] status;
    logic [15:0] addr_full;
    logic [`SEP_ARR_AW-1:0] rd_idx;
    logic [7:0] rd_data;
    logic mem_we;

    always_comb begin
        s = r;
        fifo_in_valid = 1'b0;
        fifo_in_data = '0;
        mem_we = 1'b0;
        sck_rise = sck_s && !r.sck_q;
        sck_fall = !sck_s && r.sck_q;
        cs_rise = cs_s && !r.cs_q;
        cs_fall = !cs_s && r.cs_q;
        locked = r.nv[`SEP_SR_PROTECT_ENABLE_BIT] && !wp_s; // [RULE1] [RULE3] [RULE4] [RULE5]
        nb = {r.shin[6:0], si_s}; // [RULE23]
        last = (r.bitcnt == `SEP_BIT_LAST);
        status = r.nv & `SEP_SR_NV_MASK; // [RULE22]
        status[`SEP_SR_FLAG] = r.flag;
        status[`SEP_SR_WEL] = r.write_enable_latch;
        status[`SEP_SR_BUSY] = r.busy; // [RULE17]
        addr_full = {r.addr_hi, nb};
        rd_idx = (r.phase == sep_addr) ? addr_full[`SEP_ARR_AW-1:0] : r.addr;
        rd_data = mem[rd_idx];
        s.sck_q = sck_s;
        s.cs_q = cs_s;

        // Power-up reset interval
        if (!r.por_done) begin
            s.por_cnt = r.por_cnt + 1'b1;
            if (r.por_cnt == POR_LAST) begin
                s.por_done = 1'b1;
                s.reset_out = 1'b0; // [RULE20]
            end
        end

        // Page buffer fill from the FIFO
        if (fifo_out_valid && fifo_out_ready) begin
            s.pvalid[fifo_out_data[`SEP_FIFO_W-1:8]] = 1'b1;
        end

        // Self-timed nonvolatile write
        if (r.busy) begin
            s.wcnt = r.wcnt + 1'b1;
            if (!r.busy_sr && !r.cidx[`SEP_PAGE_AW]) begin
                mem_we = r.pvalid[r.cidx[`SEP_PAGE_AW-1:0]];
                s.cidx = r.cidx + 1'b1;
            end
            if (r.wcnt == WR_LAST) begin
                s.busy = 1'b0;
                s.write_enable_latch = 1'b0; // [RULE24]
                s.pvalid = '0;
                if (r.busy_sr) begin
                    s.nv = r.pend & `SEP_SR_NV_MASK;
                end
            end
        end

        if (cs_rise && r.phase != sep_idle) begin
            s.phase = sep_idle; // [RULE9]
            s.so_oe_n = 1'b1;
            unique case (r.phase)
                sep_tail: begin
                    unique case (r.opcode)
                        `SEP_OP_SET_WEL: s.write_enable_latch = 1'b1; // [RULE11] [RULE21]
                        `SEP_OP_CLR_WEL: begin
                            s.write_enable_latch = 1'b0;
                            s.flag = 1'b0;
                        end
                        default: s.flag = 1'b1;
                    endcase
                end
                sep_wdata: begin
                    if (r.bitcnt == 3'h0 && r.got_byte && r.write_enable_latch && !r.busy) begin
                        s.busy = 1'b1; // [RULE15]
                        s.busy_sr = 1'b0;
                        s.wcnt = '0;
                        s.cidx = '0;
                    end else if (!r.busy) begin
                        s.pvalid = '0; // [RULE15]
                    end
                end
                sep_srwr: begin
                    if (r.bitcnt == 3'h0 && r.got_byte && r.write_enable_latch && !r.busy && !locked) begin
                        s.busy = 1'b1; // [RULE1] [RULE2] [RULE4]
                        s.busy_sr = 1'b1;
                        s.wcnt = '0;
                    end
                end
                default: ;
            endcase
        end else if (cs_fall && r.por_done) begin
            s.phase = sep_opc; // [RULE18]
            s.bitcnt = '0;
            s.got_byte = 1'b0;
            s.nbyte = 1'b0;
            if (!r.busy) begin
                s.pvalid = '0;
            end
        end else if (r.phase != sep_idle && sck_rise) begin
            s.shin = nb;
            s.bitcnt = r.bitcnt + 1'b1;
            unique case (r.phase)
                sep_opc: begin
                    if (last) begin
                        s.opcode = nb;
                        unique case (nb)
                            `SEP_OP_READ, `SEP_OP_WRITE: s.phase = sep_addr; // [RULE6] [RULE12]
                            `SEP_OP_RD_SR: begin
                                s.phase = sep_srrd; // [RULE10] [RULE17]
                                s.shout = status;
                            end
                            `SEP_OP_WR_SR: s.phase = sep_srwr; // [RULE16]
                            `SEP_OP_SET_WEL, `SEP_OP_CLR_WEL, `SEP_OP_SET_FLAG: s.phase = sep_tail;
                            default: s.phase = sep_ignore;
                        endcase
                        if (r.busy && nb != `SEP_OP_RD_SR) begin
                            s.phase = sep_ignore;
                        end
                    end
                end
                sep_addr: begin
                    if (last) begin
                        s.nbyte = 1'b1;
                        s.addr_hi = nb;
                        if (r.nbyte) begin
                            s.addr = rd_idx; // [RULE6] [RULE12]
                            if (r.opcode == `SEP_OP_READ) begin
                                s.phase = sep_rdata;
                                s.shout = rd_data;
                                s.addr = rd_idx + 1'b1; // [RULE7] [RULE8]
                            end else begin
                                s.phase = sep_wdata;
                            end
                        end
                    end
                end
                sep_rdata: begin
                    if (last) begin
                        s.shout = rd_data; // [RULE7]
                        s.addr = r.addr + 1'b1; // [RULE8]
                    end
                end
                sep_srrd: begin
                    if (last) begin
                        s.shout = status; // [RULE17]
                    end
                end
                sep_wdata: begin
                    if (last) begin
                        s.got_byte = 1'b1;
                        fifo_in_valid = 1'b1;
                        fifo_in_data = {r.addr[`SEP_PAGE_AW-1:0], nb};
                        s.addr[`SEP_PAGE_AW-1:0] = r.addr[`SEP_PAGE_AW-1:0] + 1'b1; // [RULE14] [RULE25]
                    end
                end
                sep_srwr: begin
                    if (r.got_byte) begin
                        s.phase = sep_ignore; // [RULE16]
                    end else if (last) begin
                        s.got_byte = 1'b1;
                        s.pend = nb;
                    end
                end
                sep_tail: s.phase = sep_ignore; // [RULE11]
                default: ;
            endcase
            if (fifo_in_valid && !fifo_in_ready) begin
                s.pvalid = '0;
                s.phase = sep_ignore;
            end
        end else if (sck_fall && (r.phase == sep_rdata || r.phase == sep_srrd)) begin
            s.so = r.shout[7]; // [RULE23]
            s.shout = {r.shout[6:0], 1'b0};
            s.so_oe_n = 1'b0;
        end
    end

    // ****************************************
    // Array and page buffer storage
    // ****************************************
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[{r.addr[`SEP_ARR_AW-1:`SEP_PAGE_AW], r.cidx[`SEP_PAGE_AW-1:0]}] <=
                pbuf[r.cidx[`SEP_PAGE_AW-1:0]];
        end
        if (fifo_out_valid && fifo_out_ready) begin
            pbuf[fifo_out_data[`SEP_FIFO_W-1:8]] <= fifo_out_data[7:0]; // [RULE14]
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.phase <= sep_idle; // [RULE18]
            r.nv <= `SEP_SR_NV_RESET;
            r.write_enable_latch <= 1'b0; // [RULE19]
            r.flag <= 1'b0;
            r.so_oe_n <= 1'b1;
            r.reset_out <= 1'b1; // [RULE20]
        end else begin
            r <= s;
        end
    end

    assign so = r.so;
    assign so_oe_n = r.so_oe_n;
    assign reset_out = r.reset_out;
endmodule

// ===== sep_eeprom_checker.sv
// Concurrent checks on the pins of the serial EEPROM block
`timescale 1ns/1ps
module sep_eeprom_checker #(
    parameter int POR_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    // Protection and reset pins
    input wire logic wp_n,
    input wire logic reset_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Cycles since reset release, saturating
    int por_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_cnt_r <= 0;
        end else if (por_cnt_r < POR_CYCLES + 4) begin
            por_cnt_r <= por_cnt_r + 1;
        end
    end

    property p_rst_state;
        $fell(rst) |-> reset_out && so_oe_n;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("reset state of outputs wrong");
    property p_por_hold;
        por_cnt_r < POR_CYCLES - 1 |-> reset_out;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("reset output released early");
    property p_por_end;
        por_cnt_r > POR_CYCLES + 2 |-> !reset_out;
    endproperty
    a_por_end: assert property (p_por_end)
        else $error("reset output held too long");
    property p_no_rerise;
        1'b1 |-> !$rose(reset_out);
    endproperty
    a_no_rerise: assert property (p_no_rerise)
        else $error("reset output rose outside reset");
    property p_quiet_in_por;
        reset_out |-> so_oe_n;
    endproperty
    a_quiet_in_por: assert property (p_quiet_in_por)
        else $error("output driven during power-up");
    property p_release;
        $rose(cs_n) |-> ##[1:6] so_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("output not released after deselect");
    property p_drive_sel;
        $fell(so_oe_n) |-> !cs_n && !sck;
    endproperty
    a_drive_sel: assert property (p_drive_sel)
        else $error("output enabled outside a selected falling phase");
    property p_so_edge;
        $changed(so) && !so_oe_n |-> !sck && !$past(sck);
    endproperty
    a_so_edge: assert property (p_so_edge)
        else $error("output changed outside low clock phase");
    property p_so_hold;
        sck && $past(sck, 4) && !so_oe_n |-> $stable(so);
    endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("output moved while clock high");
endmodule

bind sep_eeprom sep_eeprom_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n),
    .reset_out(reset_out));

// ===== sep_spi_master.sv
// Serial master model that drives the link of the EEPROM block
`timescale 1ns/1ps
module sep_spi_master (
    // Clock
    input wire logic clk,
    // Serial link
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    int half;
    int ph;
    // Select held low from power-up, clock idles low between frames
    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        si = 1'b0;
        half = 16;
        ph = 0;
    end

    // Eight halves of 125 cycles in all give a 125 ns average period
    task automatic wait_half();
        repeat (half) @(posedge clk);
        ph = (ph + 1) % 8;
        half = (ph == 7 || ph % 2 == 0) ? 16 : 15;
    endtask

    task automatic sel();
        cs_n <= 1'b0;
        wait_half();
    endtask

    // Raise select with the clock low, then keep it high for 8 cycles
    task automatic desel();
        wait_half();
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask

    // Send n bits of tx MSB first, sample so just before each rise
    task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            si <= tx[i];
            wait_half();
            rx[i] = so;
            sck <= 1'b1;
            wait_half();
            sck <= 1'b0;
        end
    endtask
endmodule

// ===== tb_sep_eeprom.sv
// Self-checking testbench of the serial EEPROM block
`timescale 1ns/1ps
module tb_sep_eeprom;
    localparam int WR_N = 1000;
    localparam int POR_N = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, so, so_oe_n, reset_out, so_line;
    logic [7:0] rx;
    logic [31:0] rd;
    int n_fail = 0;
    int n_checks = 0;

    always #2 clk = ~clk;
    assign so_line = so_oe_n ? ~so : so;

    sep_spi_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    sep_eeprom #(.WRITE_CYCLES(WR_N), .POR_CYCLES(POR_N)) dut (.clk(clk), .rst(rst),
        .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n),
        .reset_out(reset_out));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Send nb bytes of w top first (last one cut to nlast bits), then read nrd bytes
    task automatic frame(input int nb, input logic [63:0] w, input int nrd, input int nlast,
        output logic [31:0] q);
        logic [7:0] b;
        q = '0;
        m.sel();
        for (int i = nb - 1; i >= 0; i--) begin
            m.xfer((i == 0) ? nlast : 8, w[8*i +: 8], b);
        end
        for (int i = 0; i < nrd; i++) begin
            m.xfer(8, 8'h00, b);
            q = {q[23:0], b};
        end
        m.desel();
    endtask

    // Poll status until not busy, bounded
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            frame(1, 64'h05, 1, 8, rd);
            k++;
        end while (rd[0] !== 1'b0 && k < 40);
        if (k >= 40) begin
            n_fail++;
            complete_run();
        end
    endtask

    // Status write, optional pin drop while busy, then status compare
    task automatic sw(input logic [7:0] v, input logic drop, input logic [7:0] exp);
        frame(1, 64'h06, 0, 8, rd);
        frame(2, {48'h0, 8'h01, v}, 0, 8, rd);
        if (drop) begin
            @(posedge clk);
            wp_n <= 1'b0;
        end
        wait_idle();
        frame(1, 64'h04, 0, 8, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, {24'h0, exp});
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({31'h0, so_oe_n}, 32'h1);
        check({31'h0, reset_out}, 32'h1);
        repeat (POR_N + 4) @(posedge clk);
        #1;
        check({31'h0, reset_out}, 32'h0);
        // Latch opcode with select low since power-up is not taken
        m.xfer(8, 8'h06, rx);
        m.desel();
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'h00);
        // Page write across the page end, busy and latch
        frame(1, 64'h06, 0, 8, rd);
        frame(7, 64'h0207fea1b2c3d4, 0, 8, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'h03);
        wait_idle();
        check(rd, 32'h00);
        frame(1, 64'h06, 0, 8, rd);
        frame(4, 64'h020000e5, 0, 8, rd);
        wait_idle();
        frame(3, 64'h0307fe, 3, 8, rd);
        check(rd, 32'ha1b2e5);
        frame(3, 64'h0307e0, 2, 8, rd);
        check(rd, 32'hc3d4);
        // Latch not closed by select, then a write without latch
        frame(5, 64'h0602000077, 0, 8, rd);
        frame(4, 64'h02000077, 0, 8, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'h00);
        // Select raised in mid-byte
        frame(1, 64'h06, 0, 8, rd);
        frame(4, 64'h02000077, 0, 4, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'h02);
        frame(1, 64'h04, 0, 8, rd);
        frame(3, 64'h030000, 1, 8, rd);
        check(rd, 32'he5);
        // Protection bit and pin
        @(posedge clk) wp_n <= 1'b0;
        sw(8'h8c, 1'b0, 8'h8c);
        sw(8'h00, 1'b0, 8'h8c);
        @(posedge clk) wp_n <= 1'b1;
        sw(8'h80, 1'b0, 8'h80);
        sw(8'h84, 1'b1, 8'h84);
        sw(8'h00, 1'b0, 8'h84);
        // Cause flag set and clear
        frame(1, 64'h00, 0, 8, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'hc4);
        frame(1, 64'h04, 0, 8, rd);
        frame(1, 64'h05, 1, 8, rd);
        check(rd, 32'h84);
        complete_run();
    end
endmodule
